/* File: lda_pkg.sv */
package lda_pkg;
  // Counts of channels, engines, steps and pattern contents
  localparam int NCH = 4;
  localparam int NENG = 4;
  localparam int NSTEP = 4;
  localparam int NPAT = 4;
  localparam int NLVL = 5;
  localparam int NTIM = 6;

  // Clocking
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 6_000_000;
  localparam int OSC_GCD = 2_000_000;
  localparam int OSC_NUM = OSC_HZ / OSC_GCD;
  localparam int OSC_DEN = CLK_HZ / OSC_GCD;
  localparam int T_UNIT_MS = 50;
  localparam int FADE_STEPS = 256;
  localparam int STEP_TICK_CYC = T_UNIT_MS * (CLK_HZ / 1000) / FADE_STEPS;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SCALE = 8'h04;
  localparam logic [7:0] A_FADE = 8'h08;
  localparam logic [7:0] A_CURVE = 8'h0C;
  localparam logic [7:0] A_ESEL = 8'h10;
  localparam logic [7:0] A_SPAT = 8'h14;
  localparam logic [7:0] A_SEN = 8'h18;
  localparam logic [7:0] A_REP = 8'h1C;
  localparam logic [7:0] A_MAN = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_PAT = 8'h40;
  localparam logic [7:0] PAT_MASK = 8'hC0;
  localparam int PAT_IDX_LSB = 4;
  localparam int PAT_WORD_LSB = 2;

  // Field positions
  localparam int CTRL_FS = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP = 2;
  localparam int PT_LSB = 8;
  localparam int STAT_BUSY = 4;
  localparam int STAT_CH_LSB = 8;

  // Time slots inside a pattern
  localparam int TI_P0 = 0;
  localparam int TI_SL = 1;
  localparam int TI_P1 = 5;
  localparam int LV_LAST = 4;

  // Codes
  localparam logic [3:0] CODE_LIN_MAX = 4'hA;
  localparam logic [3:0] CODE_LONG0 = 4'hB;
  localparam logic [7:0] UNITS_LONG [0:4] = '{8'h14, 8'h28, 8'h50, 8'h78, 8'hA0};
  localparam logic [3:0] PT_INF = 4'hF;
  localparam logic [1:0] REP_INF = 2'h3;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_P0 = 2'b01,
    PH_SL = 2'b10,
    PH_P1 = 2'b11
  } lda_phase_t;

  // Time code to number of 50 ms units
  function automatic logic [7:0] lda_units(input logic [3:0] code);
    if (code <= CODE_LIN_MAX) begin
      return {4'h0, code};
    end
    return UNITS_LONG[3'(code - CODE_LONG0)];
  endfunction : lda_units

  // Exponential curve from PWM setting to duty
  function automatic logic [7:0] lda_exp(input logic [7:0] v);
    logic [12:0] t;
    t = {7'h00, 1'b1, v[4:0]} << v[7:5];
    return 8'((t >> 5) - 13'h0001);
  endfunction : lda_exp

  // Level k/256 of the way from a to b
  function automatic logic [7:0] lda_interp(input logic [7:0] a, input logic [7:0] b, input logic [7:0] k);
    logic signed [17:0] d;
    d = ($signed({1'b0, b}) - $signed({1'b0, a})) * $signed({1'b0, k});
    return 8'(a + 8'(d >>> 8));
  endfunction : lda_interp

  // First enabled step at or after from: {found, index}
  function automatic logic [2:0] lda_first(input logic [3:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < NSTEP; i++) begin
      if (!r[2] && 3'(i) >= from && en[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction : lda_first
endpackage : lda_pkg

/* File: lda_top.sv */
// Contract
// - Global full-scale select, 25.5 or 51 mA
// - Per-channel 8-bit current scale, reset zero
// - Sink current is full scale times code/255
// - Every channel dimmed by 8-bit PWM
// - PWM timebase from 6 MHz oscillator
// - Per-channel linear or exponential curve select
// - Manual fade only when channel fade enabled
// - Fade moves start to end in 256 steps
// - Exponential curve applies to fade steps
// - Four-bit fade time code table
// - Four engines, channel picks one by field
// - Engine runs steps zero to three in order
// - Disabled steps are skipped
// - All steps disabled: start does not launch
// - Two-bit repeat: once, one, two, forever
// - Step selects one of four patterns
// - Four patterns usable by any step
// - Pattern holds five levels, six times, count
// - Engine busy until finished or stopped
// - Global busy is OR of engine busy
// - Engine and pattern writes ignored while busy
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module lda_top
  import lda_pkg::*;
#(
  parameter int STEP_CYC = STEP_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [NCH-1:0] led_pwm,
  output logic [NCH*9-1:0] sink_tenth_ma,
  output logic full_scale_select,
  output logic engine_busy
);
  logic fs_ff;
  logic [7:0] scale_ff [NCH];
  logic [3:0] fade_en_ff;
  logic [3:0] fade_code_ff;
  logic [3:0] exp_ff;
  logic [3:0] auto_ff;
  logic [1:0] esel_ff [NCH];
  logic [1:0] spat_ff [NENG][NSTEP];
  logic [3:0] sen_ff [NENG];
  logic [1:0] rep_cfg_ff [NENG];
  logic [7:0] plvl_ff [NPAT][NLVL];
  logic [3:0] ptim_ff [NPAT][NTIM];
  logic [3:0] ppc_ff [NPAT];
  logic erun [NENG];
  logic [7:0] elvl [NENG];
  logic [1:0] estp [NENG];
  logic [7:0] mlvl [NCH];
  logic [NCH-1:0] chbusy;
  logic busy;
  logic [7:0] fade_units;

  // Step tick: one pulse per 1/256 of a 50 ms unit
  logic [15:0] tcnt_ff;
  logic tick;
  assign tick = (tcnt_ff == 16'(STEP_CYC - 1));
  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      tcnt_ff <= 16'h0000;
    end else begin
      tcnt_ff <= tcnt_ff + 16'h0001;
    end
  end

  // Fractional divider giving the 6 MHz oscillator enable
  logic [4:0] acc_ff;
  logic osc_en;
  logic [7:0] pwm_cnt_ff;
  assign osc_en = (acc_ff >= 5'(OSC_DEN - OSC_NUM));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ff <= 5'h00;
    end else if (osc_en) begin
      acc_ff <= acc_ff - 5'(OSC_DEN - OSC_NUM);
    end else begin
      acc_ff <= acc_ff + 5'(OSC_NUM);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_cnt_ff <= 8'h00;
    end else if (osc_en) begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
    end
  end

  // AHB-Lite slave: writes zero wait, reads one wait state
  logic dph_ff;
  logic dwr_ff;
  logic [7:0] dadr_ff;
  logic rd_rdy_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rmux;
  logic wr;
  logic rd_wait;
  logic is_pat;
  logic [1:0] pi;
  logic [1:0] pw;
  logic start_p;
  logic stop_p;
  assign wr = dph_ff && dwr_ff;
  assign rd_wait = dph_ff && !dwr_ff && !rd_rdy_ff;
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign is_pat = ((dadr_ff & PAT_MASK) == A_PAT);
  assign pi = dadr_ff[PAT_IDX_LSB +: 2];
  assign pw = dadr_ff[PAT_WORD_LSB +: 2];
  assign stop_p = wr && dadr_ff == A_CTRL && hwdata[CTRL_STOP];
  assign start_p = wr && dadr_ff == A_CTRL && hwdata[CTRL_START] && !hwdata[CTRL_STOP];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dph_ff <= 1'b0;
      dwr_ff <= 1'b0;
      dadr_ff <= 8'h00;
    end else if (hready) begin
      dph_ff <= hsel && htrans[1];
      dwr_ff <= hwrite;
      dadr_ff <= haddr[7:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_rdy_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      rd_rdy_ff <= rd_wait;
      if (rd_wait) begin
        hrdata_ff <= rmux;
      end
    end
  end
  always_comb begin
    rmux = 32'h0000_0000;
    if (is_pat) begin
      case (pw)
        2'h0: rmux = {plvl_ff[pi][3], plvl_ff[pi][2], plvl_ff[pi][1], plvl_ff[pi][0]};
        2'h1: rmux = {20'h00000, ppc_ff[pi], plvl_ff[pi][LV_LAST]};
        2'h2: begin
          for (int t = 0; t < NTIM; t++) rmux[t*4 +: 4] = ptim_ff[pi][t];
        end
        default: rmux = 32'h0000_0000;
      endcase
    end else begin
      case (dadr_ff)
        A_CTRL: rmux[CTRL_FS] = fs_ff;
        A_SCALE: for (int c = 0; c < NCH; c++) rmux[c*8 +: 8] = scale_ff[c];
        A_FADE: rmux[7:0] = {fade_code_ff, fade_en_ff};
        A_CURVE: rmux[7:0] = {auto_ff, exp_ff};
        A_ESEL: for (int c = 0; c < NCH; c++) rmux[c*2 +: 2] = esel_ff[c];
        A_SPAT: begin
          for (int e = 0; e < NENG; e++) begin
            for (int s = 0; s < NSTEP; s++) rmux[(e*4+s)*2 +: 2] = spat_ff[e][s];
          end
        end
        A_SEN: for (int e = 0; e < NENG; e++) rmux[e*4 +: 4] = sen_ff[e];
        A_REP: for (int e = 0; e < NENG; e++) rmux[e*2 +: 2] = rep_cfg_ff[e];
        A_MAN: for (int c = 0; c < NCH; c++) rmux[c*8 +: 8] = mlvl[c];
        A_STAT: begin
          for (int e = 0; e < NENG; e++) rmux[e] = erun[e];
          rmux[STAT_BUSY] = busy;
          rmux[STAT_CH_LSB +: NCH] = chbusy;
        end
        default: rmux = 32'h0000_0000;
      endcase
    end
  end

  // Unlocked configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fs_ff <= 1'b0;
      fade_en_ff <= 4'h0;
      fade_code_ff <= 4'h0;
      exp_ff <= 4'h0;
      auto_ff <= 4'h0;
      for (int c = 0; c < NCH; c++) begin
        scale_ff[c] <= 8'h00;
        esel_ff[c] <= 2'h0;
      end
    end else if (wr) begin
      case (dadr_ff)
        A_CTRL: fs_ff <= hwdata[CTRL_FS];
        A_SCALE: for (int c = 0; c < NCH; c++) scale_ff[c] <= hwdata[c*8 +: 8];
        A_FADE: {fade_code_ff, fade_en_ff} <= hwdata[7:0];
        A_CURVE: {auto_ff, exp_ff} <= hwdata[7:0];
        A_ESEL: for (int c = 0; c < NCH; c++) esel_ff[c] <= hwdata[c*2 +: 2];
        default: ;
      endcase
    end
  end

  // Engine configuration, frozen while any engine runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int e = 0; e < NENG; e++) begin
        sen_ff[e] <= 4'h0;
        rep_cfg_ff[e] <= 2'h0;
        for (int s = 0; s < NSTEP; s++) spat_ff[e][s] <= 2'h0;
      end
    end else if (wr && !busy) begin
      case (dadr_ff)
        A_SPAT: begin
          for (int e = 0; e < NENG; e++) begin
            for (int s = 0; s < NSTEP; s++) spat_ff[e][s] <= hwdata[(e*4+s)*2 +: 2];
          end
        end
        A_SEN: for (int e = 0; e < NENG; e++) sen_ff[e] <= hwdata[e*4 +: 4];
        A_REP: for (int e = 0; e < NENG; e++) rep_cfg_ff[e] <= hwdata[e*2 +: 2];
        default: ;
      endcase
    end
  end

  // Pattern storage, frozen while any engine runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NPAT; p++) begin
        ppc_ff[p] <= 4'h0;
        for (int l = 0; l < NLVL; l++) plvl_ff[p][l] <= 8'h00;
        for (int t = 0; t < NTIM; t++) ptim_ff[p][t] <= 4'h0;
      end
    end else if (wr && !busy && is_pat) begin
      case (pw)
        2'h0: for (int l = 0; l < LV_LAST; l++) plvl_ff[pi][l] <= hwdata[l*8 +: 8];
        2'h1: begin
          plvl_ff[pi][LV_LAST] <= hwdata[7:0];
          ppc_ff[pi] <= hwdata[PT_LSB +: 4];
        end
        2'h2: for (int t = 0; t < NTIM; t++) ptim_ff[pi][t] <= hwdata[t*4 +: 4];
        default: ;
      endcase
    end
  end

  always_comb begin
    busy = 1'b0;
    for (int e = 0; e < NENG; e++) busy = busy | erun[e];
  end
  assign engine_busy = busy;
  assign full_scale_select = fs_ff;
  assign fade_units = lda_units(fade_code_ff);

  // Animation engines
  for (genvar e = 0; e < NENG; e++) begin : g_eng
    lda_phase_t ph_ff;
    logic [1:0] seg_ff;
    logic [1:0] stp_ff;
    logic [1:0] rep_ff;
    logic [3:0] play_ff;
    logic [7:0] cnt_ff;
    logic [7:0] k_ff;
    logic [7:0] lvl_ff;
    logic [7:0] units;
    logic [1:0] pat;
    logic [1:0] n_stp;
    logic [1:0] p_n;
    logic [2:0] f_first;
    logic [2:0] f_next;
    logic used;
    logic step_adv;
    logic seg_done;
    logic enter;
    always_comb begin
      used = 1'b0;
      for (int c = 0; c < NCH; c++) used = used | (auto_ff[c] && esel_ff[c] == 2'(e));
    end
    assign pat = spat_ff[e][stp_ff];
    always_comb begin
      case (ph_ff)
        PH_P0: units = lda_units(ptim_ff[pat][TI_P0]);
        PH_SL: units = lda_units(ptim_ff[pat][3'(seg_ff) + 3'(TI_SL)]);
        PH_P1: units = lda_units(ptim_ff[pat][TI_P1]);
        default: units = 8'h00;
      endcase
    end
    assign step_adv = tick && cnt_ff == units - 8'h01;
    assign seg_done = (units == 8'h00) || (step_adv && k_ff == 8'hFF);
    assign f_first = lda_first(sen_ff[e], 3'h0);
    assign f_next = lda_first(sen_ff[e], 3'(stp_ff) + 3'h1);
    assign n_stp = (ph_ff == PH_IDLE || !f_next[2]) ? f_first[1:0] : f_next[1:0];
    assign p_n = spat_ff[e][n_stp];
    assign enter = (ph_ff == PH_IDLE && start_p && used && f_first[2]) ||
                   (ph_ff == PH_P1 && seg_done && (f_next[2] || rep_ff != 2'h0));
    always_ff @(posedge clk) begin
      if (!rst_n || stop_p) begin
        ph_ff <= PH_IDLE;
        seg_ff <= 2'h0;
        stp_ff <= 2'h0;
        rep_ff <= 2'h0;
        play_ff <= 4'h0;
        cnt_ff <= 8'h00;
        k_ff <= 8'h00;
        lvl_ff <= 8'h00;
      end else if (enter) begin
        ph_ff <= PH_P0;
        stp_ff <= n_stp;
        play_ff <= ppc_ff[p_n];
        seg_ff <= 2'h0;
        cnt_ff <= 8'h00;
        k_ff <= 8'h00;
        lvl_ff <= plvl_ff[p_n][0];
        if (ph_ff == PH_IDLE) begin
          rep_ff <= rep_cfg_ff[e];
        end else if (!f_next[2] && rep_ff != REP_INF) begin
          rep_ff <= rep_ff - 2'h1;
        end
      end else if (ph_ff != PH_IDLE && seg_done) begin
        cnt_ff <= 8'h00;
        k_ff <= 8'h00;
        case (ph_ff)
          PH_P0: begin
            if (play_ff == 4'h0) begin
              ph_ff <= PH_P1;
              lvl_ff <= plvl_ff[pat][LV_LAST];
            end else begin
              ph_ff <= PH_SL;
              seg_ff <= 2'h0;
            end
          end
          PH_SL: begin
            lvl_ff <= plvl_ff[pat][3'(seg_ff) + 3'h1];
            if (seg_ff != 2'h3) begin
              seg_ff <= seg_ff + 2'h1;
            end else if (play_ff == 4'h1) begin
              ph_ff <= PH_P1;
            end else begin
              seg_ff <= 2'h0;
              if (play_ff != PT_INF) play_ff <= play_ff - 4'h1;
            end
          end
          default: ph_ff <= PH_IDLE;
        endcase
      end else if (ph_ff != PH_IDLE && step_adv) begin
        cnt_ff <= 8'h00;
        k_ff <= k_ff + 8'h01;
        if (ph_ff == PH_SL) begin
          lvl_ff <= lda_interp(plvl_ff[pat][seg_ff], plvl_ff[pat][3'(seg_ff) + 3'h1], k_ff + 8'h01);
        end
      end else if (ph_ff != PH_IDLE && tick) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
    assign erun[e] = (ph_ff != PH_IDLE);
    assign elvl[e] = lvl_ff;
    assign estp[e] = stp_ff;
  end

  // Per-channel manual sloper, selection, curve and PWM
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic act_ff;
    logic [7:0] from_ff;
    logic [7:0] to_ff;
    logic [7:0] k_ff;
    logic [7:0] cnt_ff;
    logic [7:0] lvl_ff;
    logic [7:0] new_l;
    logic [7:0] src;
    logic [7:0] duty;
    logic [1:0] es;
    logic pwm_ff;
    logic [8:0] sink_ff;
    assign new_l = hwdata[c*8 +: 8];
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        act_ff <= 1'b0;
        from_ff <= 8'h00;
        to_ff <= 8'h00;
        k_ff <= 8'h00;
        cnt_ff <= 8'h00;
        lvl_ff <= 8'h00;
      end else if (wr && dadr_ff == A_MAN) begin
        if (fade_en_ff[c] && fade_units != 8'h00) begin
          from_ff <= lvl_ff;
          to_ff <= new_l;
          k_ff <= 8'h00;
          cnt_ff <= 8'h00;
          act_ff <= 1'b1;
        end else begin
          lvl_ff <= new_l;
          act_ff <= 1'b0;
        end
      end else if (act_ff && tick) begin
        if (cnt_ff == fade_units - 8'h01) begin
          cnt_ff <= 8'h00;
          if (k_ff == 8'hFF) begin
            act_ff <= 1'b0;
            lvl_ff <= to_ff;
          end else begin
            k_ff <= k_ff + 8'h01;
            lvl_ff <= lda_interp(from_ff, to_ff, k_ff + 8'h01);
          end
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
    assign mlvl[c] = lvl_ff;
    assign es = esel_ff[c];
    assign src = (auto_ff[c] && erun[es]) ? elvl[es] : lvl_ff;
    assign duty = exp_ff[c] ? lda_exp(src) : src;
    assign chbusy[c] = erun[es];
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pwm_ff <= 1'b0;
        sink_ff <= 9'h000;
      end else begin
        pwm_ff <= (pwm_cnt_ff < duty);
        sink_ff <= fs_ff ? {scale_ff[c], 1'b0} : {1'b0, scale_ff[c]};
      end
    end
    assign led_pwm[c] = pwm_ff;
    assign sink_tenth_ma[c*9 +: 9] = sink_ff;
  end

  busy_or_a: assert property (@(posedge clk) disable iff (!rst_n)
    engine_busy == (erun[0] | erun[1] | erun[2] | erun[3])) else $error("global busy not OR of engines");
  start_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    (start_p && sen_ff[0] == 4'h0 && !erun[0]) |=> !erun[0]) else $error("engine launched with no step");
  stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    stop_p |=> !engine_busy) else $error("engine busy after stop");
  lock_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && busy && dadr_ff == A_REP) |=> $stable(rep_cfg_ff[0]) && $stable(rep_cfg_ff[3]))
    else $error("locked register changed");
  fs_reset_a: assert property (@(posedge clk)
    !rst_n |=> !full_scale_select) else $error("full scale not cleared by reset");
  sink_calc_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 sink_tenth_ma[8:0] == ($past(fs_ff) ? {$past(scale_ff[0]), 1'b0} : {1'b0, $past(scale_ff[0])}))
    else $error("sink current wrong");
  osc_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    osc_en |=> (pwm_cnt_ff == $past(pwm_cnt_ff) + 8'h01) && !osc_en ##1 !osc_en [*4])
    else $error("oscillator enable too fast");
  man_direct_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && dadr_ff == A_MAN && !fade_en_ff[0]) |=> mlvl[0] == $past(hwdata[7:0])) else $error("direct level lost");
  step_enabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    erun[0] |-> sen_ff[0][estp[0]]) else $error("disabled step running");
endmodule : lda_top
`default_nettype wire

/* File: lda_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module led_dimming_animation_engine_bench;
  import lda_pkg::*;
  localparam int SC = 4;
  typedef struct {logic [31:0] e; int tol;} lda_note_t;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, full_scale_select, engine_busy, rd_dp, fs;
  logic [31:0] haddr, hwdata, hrdata, sc;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NCH-1:0] led_pwm;
  logic [NCH*9-1:0] sink_tenth_ma;
  int fail_count, n_compared;
  lda_note_t notes[$];
  lda_note_t nt;
  assign hready = hreadyout;
  lda_top #(.STEP_CYC(SC)) lda_top_inst (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .led_pwm(led_pwm), .sink_tenth_ma(sink_tenth_ma),
    .full_scale_select(full_scale_select), .engine_busy(engine_busy)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task wait_rdy;
    int i;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 64) begin
      fail_count++;
      $display("BAD %0t bus wait ran out", $time);
      finish_test();
    end
  endtask : wait_rdy
  // One single-word transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input int tol = 0);
    notes.push_back('{e, tol});
    bus(1'b0, a, $urandom);
  endtask : rd
  task duty(input int exp, input int tol);
    int h;
    h = 0;
    repeat (5120) begin
      @(posedge clk);
      if (led_pwm[0] === 1'b1) h++;
    end
    check(32'(h >= exp - tol && h <= exp + tol), 32'h1);
  endtask : duty
  // Read results are compared as they appear on the bus
  always @(posedge clk) begin
    if (!rst_n) begin
      rd_dp <= 1'b0;
    end else begin
      if (rd_dp && hreadyout === 1'b1) begin
        nt = notes.pop_front();
        if (nt.tol == 0) begin
          check(hrdata, nt.e);
        end else begin
          check(32'(hrdata + nt.tol >= nt.e && hrdata <= nt.e + nt.tol), 32'h1);
        end
      end
      if (hreadyout === 1'b1) rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    hsize = 3'h2;
    fail_count = 0;
    n_compared = 0;
    fs = 1'b0;
    void'($urandom(32'h231E));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped word
    rd(A_CTRL, 32'h0);
    rd(A_SCALE, 32'h0);
    rd(8'hFC, 32'h0);
    check(32'(full_scale_select), 32'h0);
    check(32'(sink_tenth_ma == '0), 32'h1);
    check(32'(hresp), 32'h0);
    // Current scale under both full-scale settings
    for (int k = 0; k < 2; k++) begin
      fs = k[0];
      sc = $urandom;
      wr(A_CTRL, {31'h0, fs});
      wr(A_SCALE, sc);
      repeat (2) @(posedge clk);
      check(32'(full_scale_select), 32'(fs));
      for (int c = 0; c < NCH; c++) begin
        check(32'(sink_tenth_ma[c*9+:9]), 32'({1'b0, sc[c*8+:8]} << fs));
      end
      rd(A_SCALE, sc);
    end
    // Direct level, then linear and exponential duty
    wr(A_FADE, 32'h0);
    wr(A_CURVE, 32'h0);
    wr(A_MAN, 32'h80);
    rd(A_MAN, 32'h80);
    duty(2560, 40);
    wr(A_CURVE, 32'h1);
    duty(300, 40);
    // Fade of one time unit from 128 down to 0
    wr(A_CURVE, 32'h0);
    wr(A_FADE, 32'h11);
    wr(A_MAN, 32'h0);
    repeat (500) @(posedge clk);
    rd(A_MAN, 32'h40, 16);
    repeat (700) @(posedge clk);
    rd(A_MAN, 32'h0);
    // Engine with no enabled step does not launch
    wr(A_ESEL, 32'h0);
    wr(A_CURVE, 32'h10);
    wr(A_SEN, 32'h0);
    wr(A_PAT + 8'h04, 32'h100);
    wr(A_PAT + 8'h08, 32'h1);
    wr(A_CTRL, {30'h0, 1'b1, fs});
    repeat (2) @(posedge clk);
    check(32'(engine_busy), 32'h0);
    rd(A_STAT, 32'h0);
    // Running engine locks its configuration until stopped
    wr(A_SEN, 32'h1);
    wr(A_CTRL, {30'h0, 1'b1, fs});
    rd(A_STAT, 32'h0F11);
    wr(A_REP, 32'h3);
    wr(A_SEN, 32'hFFFF);
    rd(A_REP, 32'h0);
    rd(A_SEN, 32'h1);
    check(32'(engine_busy), 32'h1);
    wr(A_CTRL, {29'h0, 3'b100} | 32'(fs));
    repeat (2) @(posedge clk);
    check(32'(engine_busy), 32'h0);
    rd(A_STAT, 32'h0);
    // Repeat counts stretch the run by whole passes
    for (int r = 0; r < 3; r++) begin
      wr(A_REP, 32'(r));
      wr(A_CTRL, {30'h0, 1'b1, fs});
      repeat (1024 * (r + 1) - 80) @(posedge clk);
      check(32'(engine_busy), 32'h1);
      repeat (160) @(posedge clk);
      check(32'(engine_busy), 32'h0);
    end
    // Step 1 only, playing pattern 1 held at full level, repeating forever
    wr(A_PAT + 8'h10, 32'h0000_00FF);
    wr(A_PAT + 8'h14, 32'h0000_00FF);
    wr(A_PAT + 8'h18, 32'h0000_0001);
    wr(A_SPAT, 32'h0000_0004);
    wr(A_SEN, 32'h0000_0002);
    wr(A_REP, 32'h0000_0003);
    wr(A_CTRL, {30'h0, 1'b1, fs});
    rd(A_STAT, 32'h0F11);
    duty(5100, 40);
    check(32'(engine_busy), 32'h1);
    wr(A_CTRL, {29'h0, 3'b100} | 32'(fs));
    repeat (2) @(posedge clk);
    check(32'(engine_busy), 32'h0);
    // One-second fade code, looked at halfway
    wr(A_FADE, 32'h0000_00B1);
    wr(A_MAN, 32'h0000_00FF);
    repeat (10240) @(posedge clk);
    rd(A_MAN, 32'h80, 16);
    finish_test();
  end
endmodule : led_dimming_animation_engine_bench
`default_nettype wire
